// file: epx_pkg.sv
`default_nettype none

package epx_pkg;

  // widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 9;
  localparam int STRAP_W = 6;
  localparam int CNT_W = 16;
  localparam int BANK_W = 8;

  // register byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] TX_WORD_OFS = 8'h08;
  localparam logic [7:0] RX_WORD_OFS = 8'h0C;
  localparam logic [7:0] RX_COUNT_OFS = 8'h10;
  localparam logic [7:0] BANK_OFS = 8'h14;

  // control fields
  localparam int CTRL_LINK_EN_BIT = 0;
  localparam logic CTRL_LINK_EN_RST = 1'b0;

  // status fields
  localparam int ST_STRAP_LSB = 0;
  localparam int ST_STRAPS_VALID_BIT = 6;
  localparam int ST_RX_NEW_BIT = 8;
  localparam int ST_COLLISION_BIT = 9;
  localparam int ST_CARRIER_BIT = 10;
  localparam int ST_TX_BUSY_BIT = 11;
  localparam int ST_TX_DRIVE_BIT = 12;

  // strap vector positions
  localparam int STRAP_FLOW_BIT = 0;
  localparam int STRAP_PORT7_BIT = 1;
  localparam int STRAP_AUTONEG_BIT = 2;
  localparam int STRAP_ADDR_LO_BIT = 3;
  localparam int STRAP_ADDR_HI_BIT = 4;
  localparam int STRAP_LED_BIT = 5;

  // strap defaults: flow on, port7 copper, autoneg on, addr 0, one colour
  localparam logic [STRAP_W-1:0] STRAP_RST = 6'h05;

  // synchroniser depth and strap settling after reset release
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;

  // eeprom banks per chip role
  localparam logic [BANK_W-1:0] MASTER_BANK_FIRST = 8'h00;
  localparam logic [BANK_W-1:0] MASTER_BANK_LAST = 8'h27;
  localparam logic [BANK_W-1:0] SLAVE_BANK_FIRST = 8'h40;
  localparam logic [BANK_W-1:0] SLAVE_BANK_LAST = 8'h67;
  localparam logic [1:0] MASTER_CHIP_ADDR = 2'h0;

  // transmit clock and system clock rates
  localparam int TX_CLK_MHZ = 125;
  localparam int CLK_MHZ = 10;

endpackage : epx_pkg

`default_nettype wire

// file: epx_sync.sv
`default_nettype none

module epx_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // meta_r feeds only q_r
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_r <= RST_VAL;
      q_r <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule : epx_sync

`default_nettype wire

// file: epx_strap_latch.sv
`default_nettype none

module epx_strap_latch #(
  parameter int WIDTH = epx_pkg::STRAP_W,
  parameter logic [WIDTH-1:0] RST_VAL = epx_pkg::STRAP_RST
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // raw strap pins
  input wire logic [WIDTH-1:0] strap_pins,
  // captured values
  output logic [WIDTH-1:0] strap_val,
  output logic strap_valid
);

  logic [WIDTH-1:0] pins_s;
  logic [WIDTH-1:0] strap_r;
  logic [1:0] settle_r;
  logic valid_r;

  epx_sync #(.WIDTH(WIDTH), .RST_VAL(RST_VAL)) u_sync (
    .clk(clk),
    .reset(reset),
    .d(strap_pins),
    .q(pins_s)
  );

  // wait until the synchroniser holds real pin levels
  always_ff @(posedge clk)
  begin
    if (reset)
      settle_r <= 2'h0;
    else if (settle_r != epx_pkg::STRAP_SETTLE_CYC)
      settle_r <= settle_r + 2'h1;
  end

  // one capture per reset, later pin activity ignored
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strap_r <= RST_VAL;
      valid_r <= 1'b0;
    end
    else if (!valid_r && settle_r == epx_pkg::STRAP_SETTLE_CYC)
    begin
      strap_r <= pins_s;
      valid_r <= 1'b1;
    end
  end

  assign strap_val = strap_r;
  assign strap_valid = valid_r;

endmodule : epx_strap_latch

`default_nettype wire

// file: epx_port.sv
// Summary of operation
// R1: transmit word and enable change on rising edge of our transmit clock.
// R2: we drive the 125 MHz transmit clock that times all outgoing data.
// R3: partner drives nine-bit receive word on its clock; we sample there.
// R4: partner gives valid, collision, carrier; words taken only while valid.
// R5: flow-control strap latched at reset; 0 off, 1 on, default on.
// R6: port-7 media strap latched; 0 twisted pair, 1 fibre, default 0.
// R7: auto-negotiation strap latched at reset; 0 off, 1 on, default on.
// R8: chip address from two straps picks eeprom bank 00-27 or 40-67.
// R9: controller gives one serial clock while chip select idles on writes.
// R10: led colour strap latched, serial led mode only; 0 single colour.
// R11: the reset input is the power-on reset that captures all straps.
// R12: straps sampled once after reset release, then held until next reset.
//
// Our own choices: the plain strobed port and the register addresses.
`default_nettype none

module epx_port (
  // system clock and power-on reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [epx_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [epx_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [epx_pkg::DATA_W-1:0] reg_rdata,
  // transmit side, clocked by our own source
  input wire logic tx_clk_source,
  output logic expansion_tx_clock,
  input wire logic [epx_pkg::WORD_W-1:0] expansion_tx_word_i,
  output logic [epx_pkg::WORD_W-1:0] expansion_tx_word_o,
  output logic [epx_pkg::WORD_W-1:0] expansion_tx_word_oe,
  input wire logic expansion_tx_enable_i,
  output logic expansion_tx_enable_o,
  output logic expansion_tx_enable_oe,
  // receive side, clocked by the partner
  input wire logic expansion_rx_clock,
  input wire logic [epx_pkg::WORD_W-1:0] expansion_rx_word,
  input wire logic expansion_rx_valid,
  input wire logic expansion_collision,
  input wire logic expansion_carrier_sense,
  // straps not shared with the expansion pins
  input wire logic autoneg_strap,
  input wire logic chip_address_strap_hi,
  input wire logic led_colour_strap,
  // latched configuration
  output logic straps_valid,
  output logic flow_control_enable,
  output logic port7_fibre,
  output logic autoneg_enable,
  output logic led_dual_colour,
  output logic [1:0] chip_address,
  output logic chip_is_master,
  output logic [epx_pkg::BANK_W-1:0] eeprom_bank_first,
  output logic [epx_pkg::BANK_W-1:0] eeprom_bank_last
);

  localparam int W = epx_pkg::WORD_W;

  // strap capture
  logic [epx_pkg::STRAP_W-1:0] strap_pins;
  logic [epx_pkg::STRAP_W-1:0] strap_val;
  logic strap_done;

  // strap pins share the tx pins, released while reset holds oe low
  always_comb
  begin
    strap_pins = '0;
    strap_pins[epx_pkg::STRAP_FLOW_BIT] = expansion_tx_word_i[0];
    strap_pins[epx_pkg::STRAP_PORT7_BIT] = expansion_tx_word_i[W-1];
    strap_pins[epx_pkg::STRAP_AUTONEG_BIT] = autoneg_strap;
    strap_pins[epx_pkg::STRAP_ADDR_LO_BIT] = expansion_tx_enable_i;
    strap_pins[epx_pkg::STRAP_ADDR_HI_BIT] = chip_address_strap_hi;
    strap_pins[epx_pkg::STRAP_LED_BIT] = led_colour_strap;
  end

  // reset input is the capture source [R11] [R12]
  epx_strap_latch #(
    .WIDTH(epx_pkg::STRAP_W),
    .RST_VAL(epx_pkg::STRAP_RST)
  ) u_straps (
    .clk(clk),
    .reset(reset),
    .strap_pins(strap_pins),
    .strap_val(strap_val),
    .strap_valid(strap_done)
  );

  assign straps_valid = strap_done;
  assign flow_control_enable = strap_val[epx_pkg::STRAP_FLOW_BIT]; // [R5]
  assign port7_fibre = strap_val[epx_pkg::STRAP_PORT7_BIT]; // [R6]
  assign autoneg_enable = strap_val[epx_pkg::STRAP_AUTONEG_BIT]; // [R7]
  assign led_dual_colour = strap_val[epx_pkg::STRAP_LED_BIT]; // [R10]
  assign chip_address = {strap_val[epx_pkg::STRAP_ADDR_HI_BIT],
                         strap_val[epx_pkg::STRAP_ADDR_LO_BIT]};

  // bank limits, registered so they sit still for the eeprom loader
  logic master_r;
  logic [epx_pkg::BANK_W-1:0] bank_first_r;
  logic [epx_pkg::BANK_W-1:0] bank_last_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      master_r <= 1'b1;
      bank_first_r <= epx_pkg::MASTER_BANK_FIRST;
      bank_last_r <= epx_pkg::MASTER_BANK_LAST;
    end
    else if (chip_address == epx_pkg::MASTER_CHIP_ADDR)
    begin
      master_r <= 1'b1;
      bank_first_r <= epx_pkg::MASTER_BANK_FIRST; // [R8]
      bank_last_r <= epx_pkg::MASTER_BANK_LAST;
    end
    else
    begin
      master_r <= 1'b0;
      bank_first_r <= epx_pkg::SLAVE_BANK_FIRST; // [R8]
      bank_last_r <= epx_pkg::SLAVE_BANK_LAST;
    end
  end

  assign chip_is_master = master_r;
  assign eeprom_bank_first = bank_first_r;
  assign eeprom_bank_last = bank_last_r;

  // software state
  logic link_en_r;
  logic [W-1:0] tx_data_r;
  logic tx_req_r;
  logic tx_ack_s;
  logic tx_busy;
  logic [W-1:0] rx_data_r;
  logic rx_new_r;
  logic rx_ack_r;
  logic rx_req_s;
  logic [epx_pkg::CNT_W-1:0] rx_count_r;
  logic col_s;
  logic crs_s;
  logic [epx_pkg::DATA_W-1:0] rdata_r;
  logic [W-1:0] rx_hold_r;
  logic tx_drive;
  logic rx_take;
  logic wr_ctrl;
  logic wr_tx;
  logic rd_rx;

  assign wr_ctrl = reg_wr && reg_addr == epx_pkg::CTRL_OFS;
  assign wr_tx = reg_wr && reg_addr == epx_pkg::TX_WORD_OFS;
  assign rd_rx = reg_rd && reg_addr == epx_pkg::RX_WORD_OFS;
  assign tx_busy = tx_req_r != tx_ack_s;
  assign rx_take = rx_req_s != rx_ack_r;

  always_ff @(posedge clk)
  begin
    if (reset)
      link_en_r <= epx_pkg::CTRL_LINK_EN_RST;
    else if (wr_ctrl)
      link_en_r <= reg_wdata[epx_pkg::CTRL_LINK_EN_BIT];
  end

  // a word written while the last is in flight is dropped
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_data_r <= '0;
      tx_req_r <= 1'b0;
    end
    else if (wr_tx && !tx_busy)
    begin
      tx_data_r <= reg_wdata[W-1:0];
      tx_req_r <= ~tx_req_r;
    end
  end

  // receive handover; a new word wins over a clearing read
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rx_data_r <= '0;
      rx_ack_r <= 1'b0;
      rx_new_r <= 1'b0;
      rx_count_r <= '0;
    end
    else if (rx_take)
    begin
      rx_data_r <= rx_hold_r;
      rx_ack_r <= rx_req_s;
      rx_new_r <= 1'b1;
      rx_count_r <= rx_count_r + {{(epx_pkg::CNT_W-1){1'b0}}, 1'b1};
    end
    else if (rd_rx)
      rx_new_r <= 1'b0;
  end

  // collision and carrier are asynchronous levels [R4]
  epx_sync #(.WIDTH(2)) u_line_sync (
    .clk(clk),
    .reset(reset),
    .d({expansion_collision, expansion_carrier_sense}),
    .q({col_s, crs_s})
  );

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (reset || !reg_rd)
      rdata_r <= '0;
    else
    begin
      rdata_r <= '0;
      case (reg_addr)
        epx_pkg::CTRL_OFS:
          rdata_r[epx_pkg::CTRL_LINK_EN_BIT] <= link_en_r;
        epx_pkg::STATUS_OFS:
        begin
          rdata_r[epx_pkg::ST_STRAP_LSB +: epx_pkg::STRAP_W] <= strap_val;
          rdata_r[epx_pkg::ST_STRAPS_VALID_BIT] <= strap_done;
          rdata_r[epx_pkg::ST_RX_NEW_BIT] <= rx_new_r;
          rdata_r[epx_pkg::ST_COLLISION_BIT] <= col_s;
          rdata_r[epx_pkg::ST_CARRIER_BIT] <= crs_s;
          rdata_r[epx_pkg::ST_TX_BUSY_BIT] <= tx_busy;
          rdata_r[epx_pkg::ST_TX_DRIVE_BIT] <= tx_drive;
        end
        epx_pkg::TX_WORD_OFS:
          rdata_r[W-1:0] <= tx_data_r;
        epx_pkg::RX_WORD_OFS:
          rdata_r[W-1:0] <= rx_data_r;
        epx_pkg::RX_COUNT_OFS:
          rdata_r[epx_pkg::CNT_W-1:0] <= rx_count_r;
        epx_pkg::BANK_OFS:
          rdata_r[2*epx_pkg::BANK_W-1:0] <= {bank_last_r, bank_first_r};
        default:
          rdata_r <= '0;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  // pins stay released until straps are taken and software opens the link
  assign tx_drive = strap_done && link_en_r;

  // transmit domain
  logic tx_rst;
  logic tx_req_t;
  logic tx_drive_t;
  logic tx_ack_r;
  logic [W-1:0] tx_word_r;
  logic tx_en_r;

  epx_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_tx_rst (
    .clk(tx_clk_source),
    .reset(1'b0),
    .d(reset),
    .q(tx_rst)
  );

  epx_sync #(.WIDTH(2)) u_tx_in (
    .clk(tx_clk_source),
    .reset(tx_rst),
    .d({tx_req_r, tx_drive}),
    .q({tx_req_t, tx_drive_t})
  );

  // tx_data_r is held stable while the request toggle is pending
  always_ff @(posedge tx_clk_source)
  begin
    if (tx_rst)
    begin
      tx_ack_r <= 1'b0;
      tx_word_r <= '0;
      tx_en_r <= 1'b0;
    end
    else if (tx_req_t != tx_ack_r)
    begin
      tx_ack_r <= tx_req_t;
      tx_word_r <= tx_data_r; // [R1]
      tx_en_r <= 1'b1; // [R1]
    end
    else
    begin
      tx_word_r <= '0;
      tx_en_r <= 1'b0;
    end
  end

  epx_sync #(.WIDTH(1)) u_tx_ack (
    .clk(clk),
    .reset(reset),
    .d(tx_ack_r),
    .q(tx_ack_s)
  );

  assign expansion_tx_clock = tx_clk_source; // [R2]
  assign expansion_tx_word_o = tx_word_r;
  assign expansion_tx_word_oe = {W{tx_drive_t}};
  assign expansion_tx_enable_o = tx_en_r;
  assign expansion_tx_enable_oe = tx_drive_t;

  // receive domain; partner clock may stop between frames
  logic rx_rst;
  logic rx_ack_t;
  logic rx_req_r;

  epx_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_rx_rst (
    .clk(expansion_rx_clock),
    .reset(1'b0),
    .d(reset),
    .q(rx_rst)
  );

  epx_sync #(.WIDTH(1)) u_rx_ack (
    .clk(expansion_rx_clock),
    .reset(rx_rst),
    .d(rx_ack_r),
    .q(rx_ack_t)
  );

  // one word in flight; words arriving meanwhile are lost
  always_ff @(posedge expansion_rx_clock)
  begin
    if (rx_rst)
    begin
      rx_req_r <= 1'b0;
      rx_hold_r <= '0;
    end
    else if (expansion_rx_valid && rx_req_r == rx_ack_t) // [R4]
    begin
      rx_hold_r <= expansion_rx_word; // [R3]
      rx_req_r <= ~rx_req_r;
    end
  end

  epx_sync #(.WIDTH(1)) u_rx_req (
    .clk(clk),
    .reset(reset),
    .d(rx_req_r),
    .q(rx_req_s)
  );

endmodule : epx_port

`default_nettype wire

// file: epx_port_props.sv
`default_nettype none

module epx_port_props (
  // clocks and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic tx_clk_source,
  // pins and latched straps
  input wire logic expansion_tx_clock,
  input wire logic [8:0] expansion_tx_word_i,
  input wire logic [8:0] expansion_tx_word_oe,
  input wire logic expansion_tx_enable_i,
  input wire logic expansion_tx_enable_o,
  input wire logic expansion_tx_enable_oe,
  input wire logic autoneg_strap,
  input wire logic chip_address_strap_hi,
  input wire logic led_colour_strap,
  input wire logic straps_valid,
  input wire logic flow_control_enable,
  input wire logic port7_fibre,
  input wire logic autoneg_enable,
  input wire logic led_dual_colour,
  input wire logic [1:0] chip_address,
  input wire logic chip_is_master,
  input wire logic [7:0] eeprom_bank_first,
  input wire logic [7:0] eeprom_bank_last
);
  sequence quiet_s;
    !straps_valid ##1 !straps_valid;
  endsequence
  sequence take_s;
    flow_control_enable == expansion_tx_word_i[0]
    && port7_fibre == expansion_tx_word_i[8]
    && autoneg_enable == autoneg_strap
    && led_dual_colour == led_colour_strap
    && chip_address == {chip_address_strap_hi, expansion_tx_enable_i};
  endsequence
  strap_dflt_a:
    assert property (@(posedge clk) disable iff (reset) !straps_valid
      |-> flow_control_enable && autoneg_enable && !port7_fibre
      && !led_dual_colour) else $error("default lost");
  strap_take_a:
    assert property (@(posedge clk) disable iff (reset)
      $rose(straps_valid) |-> take_s) else $error("strap wrong");
  capture_once_a:
    assert property (@(posedge clk) disable iff (reset)
      $fell(reset) |-> quiet_s ##[1:3] straps_valid)
      else $error("no capture");
  strap_hold_a:
    assert property (@(posedge clk) disable iff (reset) straps_valid
      |=> $stable({flow_control_enable, port7_fibre, autoneg_enable,
      led_dual_colour, chip_address})) else $error("strap moved");
  chip_role_a:
    assert property (@(posedge clk) disable iff (reset)
      chip_is_master == ($past(chip_address) == 2'h0))
      else $error("role wrong");
  bank_pick_a:
    assert property (@(posedge clk) disable iff (reset)
      {eeprom_bank_first, eeprom_bank_last} == (chip_is_master ?
      16'h0027 : 16'h4067)) else $error("bank wrong");
  tx_clock_a:
    assert property (@(posedge clk) disable iff (reset)
      expansion_tx_clock == tx_clk_source) else $error("clock not fed");
  tx_pulse_a:
    assert property (@(posedge tx_clk_source) disable iff (reset)
      expansion_tx_enable_o |=> !expansion_tx_enable_o)
      else $error("enable long");
  oe_gate_a:
    assert property (@(posedge clk) disable iff (reset) !straps_valid
      |-> expansion_tx_word_oe == 9'h000 && !expansion_tx_enable_oe)
      else $error("early drive");
endmodule : epx_port_props

bind epx_port epx_port_props u_props (.clk, .reset, .tx_clk_source,
  .expansion_tx_clock, .expansion_tx_word_i, .expansion_tx_word_oe,
  .expansion_tx_enable_i, .expansion_tx_enable_o, .expansion_tx_enable_oe,
  .autoneg_strap, .chip_address_strap_hi, .led_colour_strap,
  .straps_valid, .flow_control_enable, .port7_fibre, .autoneg_enable,
  .led_dual_colour, .chip_address, .chip_is_master, .eeprom_bank_first,
  .eeprom_bank_last);

`default_nettype wire

// file: epx_partner.sv
`default_nettype none

module epx_partner (
  // toward the device
  output logic rx_clk,
  output logic [8:0] rx_word,
  output logic rx_valid,
  output logic col,
  output logic crs,
  // from the device
  input wire logic tx_clk,
  input wire logic [8:0] tx_word,
  input wire logic tx_en,
  output logic [8:0] got_word,
  output int got_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {rx_clk, rx_word, rx_valid, col, crs, got_word} = '0;
    got_n = 0;
  end
  always @(posedge tx_clk)
    if (tx_en === 1'b1)
    begin
      got_word <= tx_word;
      got_n <= got_n + 1;
    end
  // clock stands still between frames
  task automatic clocks(input int n);
    repeat (n)
    begin
      #80 rx_clk = 1'b1;
      #80 rx_clk = 1'b0;
    end
  endtask : clocks
  task automatic send(input logic [8:0] w);
    // rx reset synchroniser needs two of its own edges to let go
    clocks(2);
    rx_word = w;
    rx_valid = 1'b1;
    clocks(1);
    // released word shows the inverse, not a stale copy
    rx_word = ~w;
    rx_valid = 1'b0;
    clocks(3);
  endtask : send
  task automatic lines(input logic c, input logic s);
    col = c;
    crs = s;
  endtask : lines
endmodule : epx_partner

`default_nettype wire

// file: test_epx_port.sv
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end

module test_epx_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, txc, txo, wr, rd, an, hi, led, lo, tei, teo, teoe;
  logic rxc, rxv, col, crs, sv, fl, p7, ane, ldc, mst;
  logic [1:0] ca;
  logic [7:0] addr, bf, bl;
  logic [31:0] wd, rdat, d;
  logic [8:0] sp, wi, wo, woe, rxw, pw;
  logic [5:0] vec [3] = '{6'b010101, 6'b101000, 6'b000010};
  int num_errors = 0;
  int n_tests = 0;
  int pn;
  assign wi = (woe & wo) | (~woe & sp);
  assign tei = teoe ? teo : lo;

  epx_port dut (.clk(clk), .reset(reset), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .tx_clk_source(txc),
    .expansion_tx_clock(txo), .expansion_tx_word_i(wi),
    .expansion_tx_word_o(wo), .expansion_tx_word_oe(woe),
    .expansion_tx_enable_i(tei), .expansion_tx_enable_o(teo),
    .expansion_tx_enable_oe(teoe), .expansion_rx_clock(rxc),
    .expansion_rx_word(rxw), .expansion_rx_valid(rxv),
    .expansion_collision(col), .expansion_carrier_sense(crs),
    .autoneg_strap(an), .chip_address_strap_hi(hi), .led_colour_strap(led),
    .straps_valid(sv), .flow_control_enable(fl), .port7_fibre(p7),
    .autoneg_enable(ane), .led_dual_colour(ldc), .chip_address(ca),
    .chip_is_master(mst), .eeprom_bank_first(bf), .eeprom_bank_last(bl));
  epx_partner partner (.rx_clk(rxc), .rx_word(rxw), .rx_valid(rxv),
    .col(col), .crs(crs), .tx_clk(txo), .tx_word(wo), .tx_en(teo),
    .got_word(pw), .got_n(pn));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    txc = 1'b0;
    forever #4 txc = ~txc;
  end

  task wr_r(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_r
  task rd_r(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask : rd_r
  task chk_rd(input string n, input logic [7:0] a, input logic [31:0] e);
    rd_r(a);
    `CHK(n, e, d)
  endtask : chk_rd
  // rx side needs its own edges while reset is held
  task do_reset;
    @(posedge clk);
    reset <= 1'b1;
    fork
      repeat (4) @(posedge clk);
      partner.clocks(3);
    join
    @(posedge clk);
    reset <= 1'b0;
    repeat (8) if (sv !== 1'b1) @(posedge clk);
    #1;
  endtask : do_reset

  task t_straps(input logic [5:0] v);
    logic [1:0] a;
    a = {v[4], v[3]};
    sp <= {v[1], 7'h00, v[0]};
    {led, hi, lo, an} <= {v[5], v[4], v[3], v[2]};
    do_reset();
    `CHK("flow", v[0], fl)
    `CHK("port7", v[1], p7)
    `CHK("autoneg", v[2], ane)
    `CHK("led", v[5], ldc)
    `CHK("master", a == 2'h0, mst)
    `CHK("bank", a == 2'h0 ? 16'h2700 : 16'h6740, {bl, bf})
    chk_rd("status", epx_pkg::STATUS_OFS, {25'h0, 1'b1, v});
    sp <= ~sp;
    {led, hi, lo, an} <= ~{v[5], v[4], v[3], v[2]};
    repeat (5) @(posedge clk);
    #1;
    `CHK("held", {v[0], a}, {fl, ca})
    $display("test straps done");
  endtask : t_straps

  task t_tx;
    int c;
    `CHK("oe off", 9'h000, woe)
    chk_rd("unmapped", 8'h18, 32'h0000_0000);
    wr_r(epx_pkg::CTRL_OFS, 32'h0000_0001);
    c = pn;
    wr_r(epx_pkg::TX_WORD_OFS, 32'h0000_01A5);
    repeat (40) if (pn == c) @(posedge clk);
    `CHK("tx word", 9'h1A5, pw)
    `CHK("oe on", 9'h1FF, woe)
    repeat (4) @(posedge clk);
    rd_r(epx_pkg::STATUS_OFS);
    `CHK("tx idle", 2'b10, d[12:11])
    chk_rd("tx back", epx_pkg::TX_WORD_OFS, 32'h0000_01A5);
    $display("test tx done");
  endtask : t_tx

  task t_rx;
    partner.send(9'h15A);
    repeat (6) @(posedge clk);
    rd_r(epx_pkg::STATUS_OFS);
    `CHK("rx new", 1'b1, d[8])
    chk_rd("rx word", epx_pkg::RX_WORD_OFS, 32'h0000_015A);
    chk_rd("rx count", epx_pkg::RX_COUNT_OFS, 32'h0000_0001);
    partner.lines(1'b1, 1'b0);
    repeat (4) @(posedge clk);
    rd_r(epx_pkg::STATUS_OFS);
    `CHK("col", 3'b010, d[10:8])
    partner.lines(1'b0, 1'b1);
    repeat (4) @(posedge clk);
    rd_r(epx_pkg::STATUS_OFS);
    `CHK("crs", 2'b10, d[10:9])
    $display("test rx done");
  endtask : t_rx

  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  initial
  begin
    {reset, wr, rd, addr, wd, sp} = {1'b1, 42'h0, 9'h001};
    {an, lo, hi, led} = 4'b1000;
    for (int i = 0; i < 3; i++)
      t_straps(vec[i]);
    t_tx();
    t_rx();
    conclude();
  end
  initial
  begin
    #200000;
    num_errors++;
    conclude();
  end
endmodule : test_epx_port

`default_nettype wire
